// ==== verilog/tafi_regs.svh ====
// Register offsets, field positions, reset values and counts of the flag block
`ifndef TAFI_REGS_SVH
`define TAFI_REGS_SVH

// Sizes
`define TAFI_LANES          4
`define TAFI_NUM_MON        10
`define TAFI_MON_W          16
`define TAFI_NUM_THR        4

// Monitor indices
`define TAFI_MON_TEMP       4'h0
`define TAFI_MON_VCC        4'h1
`define TAFI_MON_BIAS0      4'h2
`define TAFI_MON_RXPWR0     4'h6

// Page 0 byte positions of the two-byte monitor fields (upper byte first)
`define TAFI_PG_TEMP_BYTE   7'h16
`define TAFI_PG_VCC_BYTE    7'h1A
`define TAFI_PG_RXPWR_BYTE  7'h22
`define TAFI_PG_BIAS_BYTE   7'h2A

// Byte offsets on the register bus
`define TAFI_LANE_FLAG      12'h000
`define TAFI_LANE_MASK      12'h004
`define TAFI_CTRL           12'h008
`define TAFI_STATUS         12'h00C
`define TAFI_MON_FLAG_BASE  12'h040
`define TAFI_MON_MASK_BASE  12'h080
`define TAFI_MON_VAL_BASE   12'h0C0
`define TAFI_THR_BASE       12'h100
`define TAFI_PAGE_BASE      12'h400

// Threshold order within a monitor's block of four words
`define TAFI_THR_HI_ALARM   2'h0
`define TAFI_THR_LO_ALARM   2'h1
`define TAFI_THR_HI_WARN    2'h2
`define TAFI_THR_LO_WARN    2'h3

// Monitor flag bit positions
`define TAFI_FLG_HI_ALARM   0
`define TAFI_FLG_LO_ALARM   1
`define TAFI_FLG_HI_WARN    2
`define TAFI_FLG_LO_WARN    3

// Status bit positions
`define TAFI_ST_INT         0
`define TAFI_ST_LOWPWR      1
`define TAFI_ST_SELECT      2
`define TAFI_ST_COND_LSB    4

// Reset values
`define TAFI_THR_HI_RST     16'hFFFF
`define TAFI_THR_LO_RST     16'h0000
`define TAFI_MASK_RST       16'h0000
`define TAFI_CTRL_RST       16'h0000

`endif

// ==== verilog/tafi_pkg.sv ====
// Types shared by the transceiver flag block
package tafi_pkg;
  `include "tafi_regs.svh"

  // Per-lane conditions as seen at the lanes
  typedef struct packed {
    logic [`TAFI_LANES-1:0] tx_fault;
    logic [`TAFI_LANES-1:0] tx_los;
    logic [`TAFI_LANES-1:0] rx_los;
  } tafi_cond_s;

  // Host channel controls
  typedef struct packed {
    logic [`TAFI_LANES-1:0] rx_sq_dis;
    logic [`TAFI_LANES-1:0] tx_sq_dis;
    logic [`TAFI_LANES-1:0] rx_chan_dis;
    logic [`TAFI_LANES-1:0] tx_chan_dis;
  } tafi_ctrl_s;

  typedef logic [`TAFI_MON_W-1:0]                       tafi_word_t;
  typedef logic [`TAFI_NUM_MON-1:0][`TAFI_MON_W-1:0]    tafi_mon_t;
  typedef logic [`TAFI_NUM_THR-1:0][`TAFI_MON_W-1:0]    tafi_thr_t;
endpackage : tafi_pkg

// ==== verilog/tafi_flag_irq.sv ====
// Transceiver alarm, loss-of-signal and fault flags with masked interrupt
// How it works
// RULE1 - Compare each monitor with alarm and warning thresholds; flag and interrupt outside.
// RULE2 - Transmit input loss or transmitter fault sets a flag and raises interrupt.
// RULE3 - Receive optical input loss sets a flag and raises interrupt.
// RULE4 - Flags stay set after the cause goes away, until software clears them.
// RULE5 - Reading a flag register clears the flags it returned.
// RULE6 - Masked sources still set flags but never drive the interrupt.
// RULE7 - Transmit input loss squelches that lane's output unless squelch disabled.
// RULE8 - Transmitter fault or host channel disable turns the transmit channel off.
// RULE9 - Receive output squelches on optical loss unless disabled, or when host disables.
// RULE10 - Hardware interrupt output tells host of any alarm, warning, loss or fault.
// RULE11 - Bias current, temperature and supply voltage readable by host.
// RULE12 - Received optical power of each lane readable by host.
// RULE13 - Block only answers host accesses; never starts one itself.
// RULE14 - Host reads a two-byte monitor in one access for a coherent sample.
// RULE15 - Every monitor flag has its own volatile mask bit.
// RULE16 - Temperature at page bytes 22-23, supply voltage at bytes 26-27.
// RULE17 - Interrupt stays low while any unmasked flag is set, releases when cleared.
// RULE18 - Module reset clears flags, masks, controls and releases interrupt.
// RULE19 - Register port answers only while module select is held low.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module tafi_flag_irq
  import tafi_pkg::*;
(
  // System clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Module pins
  input  wire logic        module_select_n_i,
  input  wire logic        module_reset_n_i,
  input  wire logic        low_power_request_i,
  output logic             module_present_n_o,
  output logic             interrupt_request_n_o,
  // Lane side, on the link clock
  input  wire logic        link_clk_i,
  input  wire tafi_cond_s  lane_cond_i,
  input  wire logic        mon_valid_i,
  input  wire tafi_mon_t   mon_data_i,
  output logic             mon_ready_o,
  output logic [3:0]       tx_squelch_o,
  output logic [3:0]       tx_disable_o,
  output logic [3:0]       rx_squelch_o
);

  // Out-of-range flags of one sample against its four thresholds
  function automatic logic [3:0] out_of_range(input tafi_word_t v, input tafi_thr_t t);
    logic [3:0] f;
    f = '0;
    f[`TAFI_FLG_HI_ALARM] = v > t[`TAFI_THR_HI_ALARM];
    f[`TAFI_FLG_LO_ALARM] = v < t[`TAFI_THR_LO_ALARM];
    f[`TAFI_FLG_HI_WARN]  = v > t[`TAFI_THR_HI_WARN];
    f[`TAFI_FLG_LO_WARN]  = v < t[`TAFI_THR_LO_WARN];
    return f;
  endfunction : out_of_range

  // Byte-lane merge of a write into a 16-bit register
  function automatic tafi_word_t merge16(input tafi_word_t old, input logic [31:0] d,
                                         input logic [3:0] sel);
    tafi_word_t r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  // Page byte to monitor index; bit 4 marks a hit
  // Fields are two bytes wide, so only the even byte of each pair maps
  function automatic logic [4:0] page_mon(input logic [6:0] pb);
    logic [4:0] r;
    logic [6:0] off;
    r   = '0;
    off = '0;
    if (pb == `TAFI_PG_TEMP_BYTE) begin
      r = {1'b1, `TAFI_MON_TEMP};
    end else if (pb == `TAFI_PG_VCC_BYTE) begin
      r = {1'b1, `TAFI_MON_VCC};
    end else if (pb >= `TAFI_PG_RXPWR_BYTE && pb < `TAFI_PG_RXPWR_BYTE + 7'd8 && !pb[0]) begin
      // Offset from the field start; a slice of pb alone would alias once a
      // block of lanes crosses a 16-byte boundary
      off = pb - `TAFI_PG_RXPWR_BYTE;
      r = {1'b1, 4'(`TAFI_MON_RXPWR0 + 4'(off[6:1]))};
    end else if (pb >= `TAFI_PG_BIAS_BYTE && pb < `TAFI_PG_BIAS_BYTE + 7'd8 && !pb[0]) begin
      off = pb - `TAFI_PG_BIAS_BYTE;
      r = {1'b1, 4'(`TAFI_MON_BIAS0 + 4'(off[6:1]))};
    end
    return r;
  endfunction : page_mon

  // ---------------- Pin synchronisers ----------------
  logic       sel_n_s1_ff, sel_n_s2_ff;
  logic       mrst_n_s1_ff, mrst_n_s2_ff;
  logic       lpw_s1_ff, lpw_s2_ff;
  logic       soft_rst;
  logic       selected;

  // Two stages per pin; idle levels on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_n_s1_ff  <= 1'b1;
      sel_n_s2_ff  <= 1'b1;
      mrst_n_s1_ff <= 1'b1;
      mrst_n_s2_ff <= 1'b1;
      lpw_s1_ff    <= 1'b0;
      lpw_s2_ff    <= 1'b0;
    end else begin
      sel_n_s1_ff  <= module_select_n_i;
      sel_n_s2_ff  <= sel_n_s1_ff;
      mrst_n_s1_ff <= module_reset_n_i;
      mrst_n_s2_ff <= mrst_n_s1_ff;
      lpw_s1_ff    <= low_power_request_i;
      lpw_s2_ff    <= lpw_s1_ff;
    end
  end

  assign soft_rst = rst_i | ~mrst_n_s2_ff; // RULE18
  assign selected = ~sel_n_s2_ff;

  // ---------------- Lane conditions into clk_i ----------------
  tafi_cond_s cond_s1_ff, cond_s2_ff;

  // Levels only; a glitch shorter than a clk_i period may be missed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_s1_ff <= '0;
      cond_s2_ff <= '0;
    end else begin
      cond_s1_ff <= lane_cond_i;
      cond_s2_ff <= cond_s1_ff;
    end
  end

  // ---------------- Monitor word handshake ----------------
  logic       lrst_s1_ff, lrst_s2_ff;
  logic       req_tgl_ff;
  logic       ack_l_s1_ff, ack_l_s2_ff;
  tafi_mon_t  hold_ff;
  logic       req_s1_ff, req_s2_ff;
  logic       ack_tgl_ff;
  tafi_mon_t  mon_ff;
  logic       mon_fresh_ff;

  // Reset into the link domain
  always_ff @(posedge link_clk_i) begin
    lrst_s1_ff <= rst_i;
    lrst_s2_ff <= lrst_s1_ff;
  end

  // Only one sample in flight; hold stays stable until clk_i acknowledges
  assign mon_ready_o = (req_tgl_ff == ack_l_s2_ff) & ~lrst_s2_ff;

  // Link side: capture a sample and raise the request toggle
  always_ff @(posedge link_clk_i) begin
    if (lrst_s2_ff) begin
      req_tgl_ff  <= 1'b0;
      ack_l_s1_ff <= 1'b0;
      ack_l_s2_ff <= 1'b0;
      hold_ff     <= '0;
    end else begin
      ack_l_s1_ff <= ack_tgl_ff;
      ack_l_s2_ff <= ack_l_s1_ff;
      if (mon_valid_i && mon_ready_o) begin
        hold_ff    <= mon_data_i;
        req_tgl_ff <= ~req_tgl_ff;
      end
    end
  end

  // Clk side: copy whole sample at once so both bytes stay coherent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_s1_ff    <= 1'b0;
      req_s2_ff    <= 1'b0;
      ack_tgl_ff   <= 1'b0;
      mon_ff       <= '0;
      mon_fresh_ff <= 1'b0;
    end else begin
      req_s1_ff    <= req_tgl_ff;
      req_s2_ff    <= req_s1_ff;
      mon_fresh_ff <= req_s2_ff ^ ack_tgl_ff;
      if (req_s2_ff ^ ack_tgl_ff) begin
        mon_ff     <= hold_ff; // RULE11 RULE12 RULE14
        ack_tgl_ff <= req_s2_ff;
      end
    end
  end

  // ---------------- Register bus decode ----------------
  logic             ack_ff, err_ff;
  logic             req_new, rd_take, wr_take;
  logic [31:0]      rd_word;
  logic             rd_lane_flag, rd_mon_flag;
  logic [3:0]       idx;
  logic [4:0]       pg;
  tafi_ctrl_s       ctrl_ff;
  logic [11:0]      lane_flag_ff, lane_mask_ff;
  logic [3:0]       mon_flag_ff [`TAFI_NUM_MON];
  logic [3:0]       mon_mask_ff [`TAFI_NUM_MON];
  tafi_thr_t        thr_ff      [`TAFI_NUM_MON];
  logic             irq_pending;

  assign req_new = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  assign rd_take = req_new & selected & ~wb_we_i; // RULE13 RULE19
  assign wr_take = req_new & selected & wb_we_i;  // RULE19
  assign idx     = wb_adr_i[5:2];
  assign pg      = page_mon(wb_adr_i[8:2]);

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_word      = '0;
    rd_lane_flag = 1'b0;
    rd_mon_flag  = 1'b0;
    if (wb_adr_i == `TAFI_LANE_FLAG) begin
      rd_word[11:0] = lane_flag_ff;
      rd_lane_flag  = 1'b1;
    end else if (wb_adr_i == `TAFI_LANE_MASK) begin
      rd_word[11:0] = lane_mask_ff;
    end else if (wb_adr_i == `TAFI_CTRL) begin
      rd_word[15:0] = ctrl_ff;
    end else if (wb_adr_i == `TAFI_STATUS) begin
      rd_word[`TAFI_ST_INT]    = irq_pending;
      rd_word[`TAFI_ST_LOWPWR] = lpw_s2_ff;
      rd_word[`TAFI_ST_SELECT] = selected;
      rd_word[`TAFI_ST_COND_LSB +: 12] = cond_s2_ff;
    end else if (idx < 4'(`TAFI_NUM_MON) && wb_adr_i[1:0] == 2'b00) begin
      if (wb_adr_i[11:6] == `TAFI_MON_FLAG_BASE >> 6) begin
        rd_word[3:0] = mon_flag_ff[idx];
        rd_mon_flag  = 1'b1;
      end else if (wb_adr_i[11:6] == `TAFI_MON_MASK_BASE >> 6) begin
        rd_word[3:0] = mon_mask_ff[idx];
      end else if (wb_adr_i[11:6] == `TAFI_MON_VAL_BASE >> 6) begin
        rd_word[15:0] = mon_ff[idx]; // RULE11 RULE12
      end
    end
    if (wb_adr_i[11:8] == `TAFI_THR_BASE >> 8 && wb_adr_i[7:4] < 4'(`TAFI_NUM_MON)) begin
      rd_word[15:0] = thr_ff[wb_adr_i[7:4]][wb_adr_i[3:2]];
    end
    if (wb_adr_i[11:9] == `TAFI_PAGE_BASE >> 9 && pg[4]) begin
      rd_word[15:0] = mon_ff[pg[3:0]]; // RULE16 RULE14
    end
  end

  // One-cycle answer; error while the module is not selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_ff <= req_new & selected;  // RULE19
      err_ff <= req_new & ~selected; // RULE19
      if (rd_take) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;

  // ---------------- Controls, masks, thresholds ----------------
  // Volatile: module reset returns them to defaults
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      ctrl_ff      <= `TAFI_CTRL_RST;                                // RULE18
      lane_mask_ff <= 12'(`TAFI_MASK_RST);
      for (int i = 0; i < `TAFI_NUM_MON; i++) begin
        mon_mask_ff[i] <= 4'(`TAFI_MASK_RST);                        // RULE15
        thr_ff[i][`TAFI_THR_HI_ALARM] <= `TAFI_THR_HI_RST;
        thr_ff[i][`TAFI_THR_LO_ALARM] <= `TAFI_THR_LO_RST;
        thr_ff[i][`TAFI_THR_HI_WARN]  <= `TAFI_THR_HI_RST;
        thr_ff[i][`TAFI_THR_LO_WARN]  <= `TAFI_THR_LO_RST;
      end
    end else if (wr_take) begin
      if (wb_adr_i == `TAFI_CTRL) begin
        ctrl_ff <= merge16(ctrl_ff, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `TAFI_LANE_MASK) begin
        lane_mask_ff <= 12'(merge16(16'(lane_mask_ff), wb_dat_i, wb_sel_i));
      end else if (wb_adr_i[11:6] == `TAFI_MON_MASK_BASE >> 6 && idx < 4'(`TAFI_NUM_MON)
                   && wb_sel_i[0]) begin
        mon_mask_ff[idx] <= wb_dat_i[3:0];                           // RULE15
      end else if (wb_adr_i[11:8] == `TAFI_THR_BASE >> 8
                   && wb_adr_i[7:4] < 4'(`TAFI_NUM_MON)) begin
        thr_ff[wb_adr_i[7:4]][wb_adr_i[3:2]] <=
          merge16(thr_ff[wb_adr_i[7:4]][wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
      end
    end
  end

  // ---------------- Latched flags ----------------
  // Set wins over the clear of a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      lane_flag_ff <= '0; // RULE18
    end else begin
      lane_flag_ff <= (lane_flag_ff & ~((rd_take && rd_lane_flag) ? rd_word[11:0] : 12'h000))
                      | cond_s2_ff; // RULE2 RULE3 RULE4 RULE5
    end
  end

  // Compared only on a fresh sample, so a stale value cannot re-flag
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      for (int i = 0; i < `TAFI_NUM_MON; i++) begin
        mon_flag_ff[i] <= '0; // RULE18
      end
    end else begin
      for (int i = 0; i < `TAFI_NUM_MON; i++) begin
        mon_flag_ff[i] <= (mon_flag_ff[i] &
                           ~((rd_take && rd_mon_flag && idx == 4'(i)) ? rd_word[3:0] : 4'h0))
                          | (mon_fresh_ff ? out_of_range(mon_ff[i], thr_ff[i]) : 4'h0);
        // RULE1 RULE4 RULE5
      end
    end
  end

  // ---------------- Interrupt ----------------
  // Pending while any unmasked latched flag is set; masks gate the pin and the status bit, not the flags
  always_comb begin
    irq_pending = |(lane_flag_ff & ~lane_mask_ff); // RULE6 RULE10
    for (int i = 0; i < `TAFI_NUM_MON; i++) begin
      irq_pending = irq_pending | |(mon_flag_ff[i] & ~mon_mask_ff[i]); // RULE6
    end
  end

  // Registered pin, low while anything unmasked is pending
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      interrupt_request_n_o <= 1'b1;          // RULE18
    end else begin
      interrupt_request_n_o <= ~irq_pending;  // RULE10 RULE17
    end
  end

  // Always fitted, so presence reads low from power-up
  assign module_present_n_o = 1'b0;

  // ---------------- Lane outputs on the link clock ----------------
  tafi_ctrl_s ctrl_s1_ff, ctrl_s2_ff;

  // Control bits are quasi-static; per-bit sync is enough
  always_ff @(posedge link_clk_i) begin
    if (lrst_s2_ff) begin
      ctrl_s1_ff   <= `TAFI_CTRL_RST;
      ctrl_s2_ff   <= `TAFI_CTRL_RST;
      tx_squelch_o <= '0;
      tx_disable_o <= '0;
      rx_squelch_o <= '0;
    end else begin
      ctrl_s1_ff   <= ctrl_ff;
      ctrl_s2_ff   <= ctrl_s1_ff;
      tx_squelch_o <= lane_cond_i.tx_los & ~ctrl_s2_ff.tx_sq_dis;        // RULE7
      tx_disable_o <= lane_cond_i.tx_fault | ctrl_s2_ff.tx_chan_dis;     // RULE8
      rx_squelch_o <= (lane_cond_i.rx_los & ~ctrl_s2_ff.rx_sq_dis)
                      | ctrl_s2_ff.rx_chan_dis;                          // RULE9
    end
  end

endmodule : tafi_flag_irq

// ==== tb/tafi_flag_irq_monitor.sv ====
// Port checks for the transceiver flag block
`timescale 1ns/10ps
module tafi_flag_irq_monitor
  import tafi_pkg::*;
(
  // Clocks and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        link_clk_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [31:0] wb_dat_o,
  // Pins and lanes
  input wire logic        module_select_n_i,
  input wire logic        module_reset_n_i,
  input wire logic        interrupt_request_n_o,
  input wire tafi_cond_s  lane_cond_i,
  input wire logic [3:0]  tx_squelch_o,
  input wire logic [3:0]  tx_disable_o
);
  // Link reset trails rst_i by a few link edges; one stage more than the design
  logic [2:0] lrst_ff = 3'h7;
  always_ff @(posedge link_clk_i) begin
    lrst_ff <= {lrst_ff[1:0], rst_i};
  end

  // A fresh request and its single answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_ans;
    wb_ack_o ^ wb_err_o;
  endsequence

  a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req |=> s_ans) else $error("bus request not answered next cycle");
  a_answer_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ans |=> !wb_ack_o && !wb_err_o) else $error("answer longer than one cycle");
  a_ack_selected: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> !$past(module_select_n_i, 3)) else $error("ack while deselected");
  a_err_deselected: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_err_o |-> $past(module_select_n_i, 3)) else $error("err while selected");
  a_data_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o && !wb_err_o |-> $stable(wb_dat_o)) else $error("read data moved");
  a_irq_reset: assert property (@(posedge clk_i)
    rst_i |=> interrupt_request_n_o) else $error("interrupt low after reset");
  a_modrst_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    !module_reset_n_i [*4] |=> interrupt_request_n_o) else $error("irq in module reset");
  a_fault_disables: assert property (@(posedge link_clk_i) disable iff (lrst_ff != 3'h0)
    ($past(lane_cond_i.tx_fault) & ~tx_disable_o) == 4'h0) else $error("fault lane on");
  a_squelch_cause: assert property (@(posedge link_clk_i) disable iff (lrst_ff != 3'h0)
    (tx_squelch_o & ~$past(lane_cond_i.tx_los)) == 4'h0) else $error("squelch no loss");
endmodule : tafi_flag_irq_monitor

bind tafi_flag_irq tafi_flag_irq_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .link_clk_i(link_clk_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o), .module_select_n_i(module_select_n_i),
  .module_reset_n_i(module_reset_n_i), .interrupt_request_n_o(interrupt_request_n_o),
  .lane_cond_i(lane_cond_i), .tx_squelch_o(tx_squelch_o), .tx_disable_o(tx_disable_o));

// ==== tb/tafi_lane_model.sv ====
// Lane condition and monitor sample source on the link clock
`timescale 1ns/10ps
module tafi_lane_model
  import tafi_pkg::*;
(
  // Link clock and handshake
  input  wire logic link_clk_i,
  input  wire logic mon_ready_i,
  // Lane levels and samples
  output tafi_cond_s cond_o,
  output logic       mon_valid_o,
  output tafi_mon_t  mon_data_o
);
  initial begin
    cond_o = '0;
    mon_valid_o = 1'b0;
    mon_data_o = '0;
  end

  // Levels change just after a link edge
  task automatic put(input tafi_cond_s c);
    @(posedge link_clk_i);
    cond_o <= c;
  endtask : put

  // Whole sample held until taken; gap gives a slow source
  task automatic send(input tafi_mon_t d, input int gap);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge link_clk_i);
    mon_valid_o <= 1'b1;
    mon_data_o  <= d;
    do begin
      @(posedge link_clk_i);
      n++;
    end while (mon_ready_i !== 1'b1 && n < 64);
    mon_valid_o <= 1'b0;
    mon_data_o  <= ~d; // Stale data never looks current
  endtask : send
endmodule : tafi_lane_model

// ==== tb/tb_tafi_flag_irq.sv ====
// Self-checking bench for the transceiver flag block
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_tafi_flag_irq
  import tafi_pkg::*;
;
  int         fail_count = 0;
  int         check_count = 0;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       link_clk_i = 1'b0;
  logic [11:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic       wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'hF;
  logic       pres_n;
  logic       wb_cyc_i = 1'b0;
  logic       wb_stb_i = 1'b0;
  logic       sel_n = 1'b0;
  logic       mrst_n = 1'b1;
  logic       lpr = 1'b0;
  logic [31:0] wb_dat_o;
  logic       wb_ack_o;
  logic       wb_err_o;
  logic       irq_n;
  logic       mon_ready;
  logic       mon_valid;
  logic [3:0] tx_sq;
  logic [3:0] tx_dis;
  logic [3:0] rx_sq;
  tafi_cond_s cond;
  tafi_mon_t  mon;
  tafi_mon_t  s;

  // 100 ns system clock, 30 ns link clock offset in phase
  always #50 clk_i = ~clk_i;
  initial begin
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end

  tafi_flag_irq i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .module_select_n_i(sel_n), .module_reset_n_i(mrst_n), .low_power_request_i(lpr),
    .module_present_n_o(pres_n), .interrupt_request_n_o(irq_n), .link_clk_i(link_clk_i),
    .lane_cond_i(cond), .mon_valid_i(mon_valid), .mon_data_i(mon), .mon_ready_o(mon_ready),
    .tx_squelch_o(tx_sq), .tx_disable_o(tx_dis), .rx_squelch_o(rx_sq));

  tafi_lane_model u_lane (.link_clk_i(link_clk_i), .mon_ready_i(mon_ready), .cond_o(cond),
    .mon_valid_o(mon_valid), .mon_data_o(mon));

  // One classic cycle, held until ack or err is sampled
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    e = wb_err_o;
    if (n >= 20) fail_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic [31:0] m = 32'hFFFF_FFFF, input logic xe = 1'b0);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    `CHK(r & m, x)
    `CHK(e, xe)
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Watchdog well beyond the expected run
  initial begin
    cyc(6000);
    fail_count++;
    print_verdict();
  end

  initial begin
    cyc(3);
    rst_i <= 1'b0;
    cyc(4);
    rd(12'h008, 32'h0000_0000);
    rd(12'h100, 32'h0000_FFFF);
    rd(12'h300, 32'h0000_0000);
    `CHK(irq_n, 1'b1)
    `CHK(pres_n, 1'b0)
    $display("test reset done");
    // Loss flags latch, clear on read
    u_lane.put(12'h002);
    cyc(6);
    `CHK(rx_sq, 4'h2)
    `CHK(irq_n, 1'b0)
    u_lane.put(12'h840);
    cyc(6);
    `CHK(tx_sq, 4'h4)
    `CHK(tx_dis, 4'h8)
    u_lane.put(12'h000);
    cyc(6);
    `CHK(irq_n, 1'b0)
    rd(12'h000, 32'h0000_0842);
    rd(12'h000, 32'h0000_0000);
    cyc(2);
    `CHK(irq_n, 1'b1)
    $display("test lane done");
    // Masked loss sets its flag quietly
    wr(12'h004, 32'h0000_0001);
    u_lane.put(12'h001);
    cyc(6);
    `CHK(irq_n, 1'b1)
    u_lane.put(12'h000);
    cyc(6);
    rd(12'h000, 32'h0000_0001);
    // Host channel disable and squelch disable
    wr(12'h008, 32'h0000_0F21);
    u_lane.put(12'h0F0);
    cyc(8);
    `CHK(tx_dis, 4'h1)
    `CHK(rx_sq, 4'h2)
    `CHK(tx_sq, 4'h0)
    u_lane.put(12'h000);
    wr(12'h008, 32'h0000_0000);
    cyc(6);
    rd(12'h000, 32'h0000_00F0);
    // Upper byte lane alone reaches the squelch disable bits
    wb_sel_i <= 4'h2;
    wr(12'h008, 32'h0000_FFFF);
    wb_sel_i <= 4'hF;
    rd(12'h008, 32'h0000_FF00);
    wr(12'h008, 32'h0000_0000);
    $display("test control done");
    // Thresholds, monitor values and masked monitor flag
    wr(12'h100, 32'h0000_1000);
    wr(12'h11C, 32'h0000_0D00);
    wr(12'h084, 32'h0000_0008);
    s = '0;
    s[0] = 16'h2000;
    s[1] = 16'h0C00;
    s[2] = 16'h0456;
    s[6] = 16'h0123;
    s[5] = 16'h0789;
    s[9] = 16'h0345;
    u_lane.send(s, 0);
    cyc(12);
    rd(12'h458, 32'h0000_2000);
    rd(12'h468, 32'h0000_0C00);
    rd(12'h4A8, 32'h0000_0456);
    rd(12'h4C0, 32'h0000_0789);
    rd(12'h4A0, 32'h0000_0345);
    rd(12'h0D8, 32'h0000_0123);
    `CHK(irq_n, 1'b0)
    rd(12'h040, 32'h0000_0001);
    rd(12'h040, 32'h0000_0000);
    cyc(2);
    `CHK(irq_n, 1'b1)
    rd(12'h044, 32'h0000_0008);
    s[0] = 16'h0800;
    u_lane.send(s, 7);
    cyc(12);
    rd(12'h0C0, 32'h0000_0800);
    rd(12'h040, 32'h0000_0000);
    $display("test monitor done");
    // Deselected port refuses, status pins
    sel_n <= 1'b1;
    cyc(5);
    wr(12'h008, 32'h0000_000F);
    rd(12'h008, 32'h0000_0000, 32'h0000_0000, 1'b1);
    sel_n <= 1'b0;
    lpr   <= 1'b1;
    cyc(5);
    rd(12'h008, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0006, 32'h0000_0006);
    // Module reset pin restores masks and thresholds
    wr(12'h004, 32'h0000_0FFF);
    mrst_n <= 1'b0;
    cyc(6);
    mrst_n <= 1'b1;
    cyc(4);
    rd(12'h004, 32'h0000_0000);
    rd(12'h100, 32'h0000_FFFF);
    $display("test pins done");
    print_verdict();
  end
endmodule : tb_tafi_flag_irq
